/* hw/psp_pkg.sv */
// package of constants for the serial programming port
// assumes a 250 MHz system clock and a host-driven serial clock
//
// Overview of operation
// RQ1 - each rising serial clock edge shifts one data bit into a 24-bit shift register.
// RQ2 - the host sends words most significant bit first, the last two bits being the latch select code.
// RQ3 - a rising load strobe copies the shift register into exactly one of four latches.
// RQ4 - a low chip power control input powers the device down and floats the charge pump output.
// RQ5 - a high chip power control input powers up only when the soft power-down bit is clear.
// RQ6 - the status mux output shows lock detect, divided feedback or divided reference as selected.
// RQ7 - the latch select code sits in bits one and zero, bit one being the upper select bit.
// RQ8 - code 00 selects the reference latch, 01 the feedback latch, 10 the function latch, 11 the init latch.
// RQ9 - while the load strobe stays low no latch changes, only the shift register.
`default_nettype none
package psp_pkg;
    localparam int PSP_WORD_W = 24;
    localparam int PSP_SEL_UPPER_POS = 1;
    localparam int PSP_SEL_LOWER_POS = 0;
    localparam logic [1:0] PSP_SEL_REF = 2'h0;
    localparam logic [1:0] PSP_SEL_FB = 2'h1;
    localparam logic [1:0] PSP_SEL_FUNC = 2'h2;
    localparam logic [1:0] PSP_SEL_INIT = 2'h3;
    // function latch fields
    localparam int PSP_SOFT_PD_POS = 3;
    localparam int PSP_MUX_SEL_LSB = 4;
    localparam int PSP_MUX_SEL_W = 3;
    localparam int PSP_CP_TRISTATE_POS = 7;
    localparam logic [2:0] PSP_MUX_LOCK = 3'h1;
    localparam logic [2:0] PSP_MUX_FB = 3'h2;
    localparam logic [2:0] PSP_MUX_REF = 3'h4;
    localparam logic [PSP_WORD_W-1:0] PSP_LATCH_RST = 24'h000000;
endpackage : psp_pkg
`default_nettype wire

/* hw/psp_sync3.sv */
// three-stage synchroniser with agreement filter
// assumes an asynchronous input and an active-low reset of the sampling domain
`default_nettype none
module psp_sync3 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] q_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            q_ff <= '0;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    q_ff[i] <= s3_ff[i];
                end
            end
        end
    end
    assign q = q_ff;
endmodule // psp_sync3
`default_nettype wire

/* hw/psp_serial_port.sv */
// serial programming port: shift register on the link clock, latches on the load strobe,
// copies of the latches, power and status logic on the system clock
// assumes the host keeps serial clock still while load strobe is high
`default_nettype none
module psp_serial_port
    import psp_pkg::*;
#(
    parameter int WORD_W = PSP_WORD_W
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // serial link
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic load_strobe,
    // chip power control pin
    input wire logic chip_enable,
    // internal status sources
    input wire logic lock_detect,
    input wire logic fb_divided,
    input wire logic ref_divided,
    // outputs
    output logic status_mux_output,
    output logic powered_up,
    output logic charge_pump_output,
    output logic charge_pump_oe,
    output logic [WORD_W-1:0] ref_latch,
    output logic [WORD_W-1:0] fb_latch,
    output logic [WORD_W-1:0] func_latch,
    output logic [WORD_W-1:0] init_latch,
    // charge pump drive request from the loop
    input wire logic pump_drive
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    logic rst_n_sync;
    assign rst_n_sync = rst_sync_ff[1];

    // ----------------------------------------
    // link domain: shift register
    // ----------------------------------------
    typedef struct packed {
        logic [WORD_W-1:0] shift;
    } psp_link_type;
    psp_link_type link_ff;
    psp_link_type nxt_link;
    always_comb begin
        nxt_link = link_ff;
        nxt_link.shift = {link_ff.shift[WORD_W-2:0], ser_data}; // RQ1
    end
    always_ff @(posedge ser_clk) begin
        link_ff <= nxt_link;
    end

    // ----------------------------------------
    // load domain: latches update on strobe rise
    // ----------------------------------------
    typedef struct packed {
        logic [WORD_W-1:0] ref_l;
        logic [WORD_W-1:0] fb_l;
        logic [WORD_W-1:0] func_l;
        logic [WORD_W-1:0] init_l;
        logic toggle;
    } psp_latch_type;
    psp_latch_type lat_ff;
    psp_latch_type nxt_lat;
    logic [1:0] sel;
    assign sel = {link_ff.shift[PSP_SEL_UPPER_POS], link_ff.shift[PSP_SEL_LOWER_POS]}; // RQ7
    always_comb begin
        nxt_lat = lat_ff;
        nxt_lat.toggle = ~lat_ff.toggle;
        unique case (sel) // RQ3 RQ8
            PSP_SEL_REF: nxt_lat.ref_l = link_ff.shift;
            PSP_SEL_FB: nxt_lat.fb_l = link_ff.shift;
            PSP_SEL_FUNC: nxt_lat.func_l = link_ff.shift;
            PSP_SEL_INIT: nxt_lat.init_l = link_ff.shift;
        endcase
    end
    // only a strobe rise clocks the latches, so shifting alone leaves them alone
    always_ff @(posedge load_strobe or negedge rst_n_sync) begin // RQ9
        if (!rst_n_sync) begin
            lat_ff <= '0;
        end else begin
            lat_ff <= nxt_lat;
        end
    end

    // ----------------------------------------
    // crossing into the system domain
    // ----------------------------------------
    logic [2:0] tog_s1_ff;
    logic tog_seen_ff;
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            tog_s1_ff <= 3'h0;
        end else begin
            tog_s1_ff <= {tog_s1_ff[1:0], lat_ff.toggle};
        end
    end
    logic new_word;
    assign new_word = (tog_s1_ff[2] == tog_s1_ff[1]) && (tog_s1_ff[2] != tog_seen_ff);

    logic [3:0] pins_sync;
    psp_sync3 #(.WIDTH(4)) u_pin_sync (
        .clk(sys_clk),
        .rst_n(rst_n_sync),
        .d({chip_enable, lock_detect, fb_divided, ref_divided}),
        .q(pins_sync)
    );

    // ----------------------------------------
    // system domain state
    // ----------------------------------------
    typedef struct packed {
        logic tog_seen;
        logic [WORD_W-1:0] ref_l;
        logic [WORD_W-1:0] fb_l;
        logic [WORD_W-1:0] func_l;
        logic [WORD_W-1:0] init_l;
        logic up;
        logic mux;
        logic cp;
        logic cp_oe;
    } psp_sys_type;
    psp_sys_type sys_ff;
    psp_sys_type nxt_sys;
    logic [PSP_MUX_SEL_W-1:0] mux_sel;
    assign mux_sel = sys_ff.func_l[PSP_MUX_SEL_LSB +: PSP_MUX_SEL_W];
    assign tog_seen_ff = sys_ff.tog_seen;
    always_comb begin
        nxt_sys = sys_ff;
        if (new_word) begin
            nxt_sys.tog_seen = tog_s1_ff[2];
            nxt_sys.ref_l = lat_ff.ref_l;
            nxt_sys.fb_l = lat_ff.fb_l;
            nxt_sys.func_l = lat_ff.func_l;
            nxt_sys.init_l = lat_ff.init_l;
        end
        nxt_sys.up = pins_sync[3] && !sys_ff.func_l[PSP_SOFT_PD_POS]; // RQ4 RQ5
        nxt_sys.cp_oe = nxt_sys.up && !sys_ff.func_l[PSP_CP_TRISTATE_POS]; // RQ4
        nxt_sys.cp = nxt_sys.cp_oe && pump_drive;
        unique case (mux_sel) // RQ6
            PSP_MUX_LOCK: nxt_sys.mux = pins_sync[2];
            PSP_MUX_FB: nxt_sys.mux = pins_sync[1];
            PSP_MUX_REF: nxt_sys.mux = pins_sync[0];
            default: nxt_sys.mux = 1'b0;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            sys_ff <= '0;
        end else begin
            sys_ff <= nxt_sys;
        end
    end
    assign status_mux_output = sys_ff.mux;
    assign powered_up = sys_ff.up;
    assign charge_pump_output = sys_ff.cp;
    assign charge_pump_oe = sys_ff.cp_oe;
    assign ref_latch = sys_ff.ref_l;
    assign fb_latch = sys_ff.fb_l;
    assign func_latch = sys_ff.func_l;
    assign init_latch = sys_ff.init_l;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // shift register has no reset: skip its first edge
    a_shift_one_bit: assert property (@(posedge ser_clk) // RQ1
        1'b1 |=> (link_ff.shift[0] == $past(ser_data)))
        else $error("shift register lost a bit");
    a_latch_ref_only: assert property (@(posedge load_strobe) disable iff (!rst_n) // RQ3
        ($past(sel) == PSP_SEL_REF) |-> (lat_ff.fb_l == $past(lat_ff.fb_l)))
        else $error("wrong latch written");
    a_pd_floats_cp: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // RQ4
        !pins_sync[3] |=> !charge_pump_oe && !powered_up)
        else $error("charge pump driven in power down");
    a_soft_pd: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // RQ5
        (pins_sync[3] && !func_latch[PSP_SOFT_PD_POS]) |=> powered_up)
        else $error("power up not granted");
    a_mux_lock: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // RQ6
        (mux_sel == PSP_MUX_LOCK && $stable(mux_sel)) |=> status_mux_output == $past(pins_sync[2]))
        else $error("mux output wrong");
    a_sel_bits: assert property (@(posedge load_strobe) disable iff (!rst_n) // RQ7 RQ8
        ($past(sel) == PSP_SEL_INIT) |-> lat_ff.init_l[1:0] == 2'h3)
        else $error("init latch select bits wrong");
    a_latch_hold: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // RQ9
        !new_word |=> $stable(ref_latch) && $stable(func_latch))
        else $error("latch changed without a load");
    a_word_lands: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // RQ3
        new_word |=> func_latch == $past(lat_ff.func_l))
        else $error("loaded word did not reach system latches");
    a_ref_gets_word: assert property (@(posedge load_strobe) disable iff (!rst_n) // RQ8
        ($past(sel) == PSP_SEL_REF) |-> (lat_ff.ref_l == $past(link_ff.shift)))
        else $error("reference latch missed its word");
    a_fb_gets_word: assert property (@(posedge load_strobe) disable iff (!rst_n) // RQ8
        ($past(sel) == PSP_SEL_FB) |-> (lat_ff.fb_l == $past(link_ff.shift)))
        else $error("feedback latch missed its word");
    a_func_gets_word: assert property (@(posedge load_strobe) disable iff (!rst_n) // RQ8
        ($past(sel) == PSP_SEL_FUNC) |-> (lat_ff.func_l == $past(link_ff.shift)))
        else $error("function latch missed its word");
    a_init_gets_word: assert property (@(posedge load_strobe) disable iff (!rst_n) // RQ8
        ($past(sel) == PSP_SEL_INIT) |-> (lat_ff.init_l == $past(link_ff.shift)))
        else $error("init latch missed its word");
    a_cp_quiet_off: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // RQ4
        !charge_pump_oe |-> !charge_pump_output)
        else $error("charge pump output active while floating");
    a_cp_tristate: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // RQ4
        func_latch[PSP_CP_TRISTATE_POS] |=> !charge_pump_oe)
        else $error("charge pump driven while three-state requested");
    a_soft_pd_down: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // RQ5
        func_latch[PSP_SOFT_PD_POS] |=> !powered_up)
        else $error("powered up despite soft power-down");
    a_mux_fb: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // RQ6
        (mux_sel == PSP_MUX_FB) |=> status_mux_output == $past(pins_sync[1]))
        else $error("mux output wrong for feedback");
    a_mux_ref: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // RQ6
        (mux_sel == PSP_MUX_REF) |=> status_mux_output == $past(pins_sync[0]))
        else $error("mux output wrong for reference");
endmodule // psp_serial_port
`default_nettype wire

/* dv/psp_host_model.sv */
// host model driving the serial programming link
// assumes its tasks are called one at a time by the bench
`default_nettype none
module psp_host_model (
    // serial link
    output logic ser_clk,
    output logic ser_data,
    output logic load_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------
    // link drive
    // ------------------------------------------
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_strobe = 1'b0;
    end
    // link clock runs only inside the frame, 12 ns period plus the gap argument
    task automatic shift_word(input logic [23:0] w, input int gap);
        #1.3;
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            #6 ser_clk = 1'b1;
            #6 ser_clk = 1'b0;
            #(gap);
        end
        // data no longer held: show the inverse
        #6 ser_data = ~w[0];
    endtask
    // link clock stays idle while the strobe is high
    task automatic pulse_load();
        #10 load_strobe = 1'b1;
        #24 load_strobe = 1'b0;
        #4;
    endtask
endmodule // psp_host_model
`default_nettype wire

/* dv/psp_serial_port_bench.sv */
// self-checking bench for the serial programming port
// assumes the host model drives the link; latches reset to zero
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
`define WAITFOR(c) begin int k; k = 0; while (!(c) && k < 80) begin @(negedge sys_clk); k++; end if (!(c)) begin n_errors++; stop_test(); end end
module psp_serial_port_bench
    import psp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst_n, ser_clk, ser_data, load_strobe, chip_enable;
    logic lock_detect, fb_divided, ref_divided, pump_drive;
    logic status_mux_output, powered_up, charge_pump_output, charge_pump_oe;
    logic [PSP_WORD_W-1:0] lat [4];
    logic [PSP_WORD_W-1:0] exp_lat [4];
    int n_errors = 0;
    int tests_run = 0;
    psp_serial_port psp_serial_port_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ser_clk(ser_clk),
        .ser_data(ser_data), .load_strobe(load_strobe), .chip_enable(chip_enable),
        .lock_detect(lock_detect), .fb_divided(fb_divided), .ref_divided(ref_divided),
        .status_mux_output(status_mux_output), .powered_up(powered_up),
        .charge_pump_output(charge_pump_output), .charge_pump_oe(charge_pump_oe),
        .ref_latch(lat[0]), .fb_latch(lat[1]), .func_latch(lat[2]), .init_latch(lat[3]),
        .pump_drive(pump_drive));
    psp_host_model psp_host_model_inst (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));
    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic load_word(input logic [PSP_WORD_W-1:0] w);
        psp_host_model_inst.shift_word(w, 0);
        psp_host_model_inst.pulse_load();
        exp_lat[w[1:0]] = w;
        `WAITFOR(lat[w[1:0]] === w)
        for (int i = 0; i < 4; i++) `CHK(lat[i], exp_lat[i])
    endtask
    task automatic set_src(input logic [2:0] s);
        @(posedge sys_clk);
        lock_detect <= s[0];
        fb_divided <= s[1];
        ref_divided <= s[2];
    endtask
    task automatic t_codes();
        for (int c = 0; c < 4; c++) load_word({8'h5a ^ 8'(c), 14'h2c3d, 2'(c)});
    endtask
    // shifting alone must not touch any latch, slow host
    task automatic t_no_load();
        psp_host_model_inst.shift_word(24'h3cc3a5, 40);
        repeat (30) @(posedge sys_clk);
        for (int i = 0; i < 4; i++) `CHK(lat[i], exp_lat[i])
        psp_host_model_inst.pulse_load();
        exp_lat[1] = 24'h3cc3a5;
        `WAITFOR(lat[1] === exp_lat[1])
        for (int i = 0; i < 4; i++) `CHK(lat[i], exp_lat[i])
    endtask
    task automatic t_power();
        @(posedge sys_clk);
        pump_drive <= 1'b1;
        load_word(24'h000012);
        `CHK(powered_up, 1'b0)
        `CHK(charge_pump_oe, 1'b0)
        `CHK(charge_pump_output, 1'b0)
        @(posedge sys_clk);
        chip_enable <= 1'b1;
        `WAITFOR(powered_up === 1'b1)
        `CHK(powered_up, 1'b1)
        `CHK(charge_pump_oe, 1'b1)
        `CHK(charge_pump_output, 1'b1)
        @(posedge sys_clk);
        pump_drive <= 1'b0;
        `WAITFOR(charge_pump_output === 1'b0)
        `CHK(charge_pump_oe, 1'b1)
        // three-state bit floats the pump while powered
        load_word(24'h000092);
        `WAITFOR(charge_pump_oe === 1'b0)
        `CHK(powered_up, 1'b1)
        load_word(24'h000012);
        `WAITFOR(charge_pump_oe === 1'b1)
        @(posedge sys_clk);
        chip_enable <= 1'b0;
        `WAITFOR(powered_up === 1'b0)
        `CHK(charge_pump_oe, 1'b0)
        @(posedge sys_clk);
        chip_enable <= 1'b1;
        `WAITFOR(powered_up === 1'b1)
        load_word(24'h00001a);
        `WAITFOR(powered_up === 1'b0)
        `CHK(powered_up, 1'b0)
        `CHK(charge_pump_oe, 1'b0)
    endtask
    task automatic t_mux();
        logic [2:0] sel [3] = '{PSP_MUX_LOCK, PSP_MUX_FB, PSP_MUX_REF};
        for (int i = 0; i < 3; i++) begin
            load_word({17'h0, sel[i], 4'h2});
            set_src(sel[i]);
            `WAITFOR(status_mux_output === 1'b1)
            `CHK(status_mux_output, 1'b1)
            set_src(~sel[i]);
            `WAITFOR(status_mux_output === 1'b0)
            `CHK(status_mux_output, 1'b0)
        end
        // unlisted select code shows nothing
        load_word({17'h0, 3'h7, 4'h2});
        set_src(3'h7);
        repeat (8) @(negedge sys_clk);
        `CHK(status_mux_output, 1'b0)
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        rst_n = 1'b0;
        chip_enable = 1'b0;
        lock_detect = 1'b0;
        fb_divided = 1'b0;
        ref_divided = 1'b0;
        pump_drive = 1'b0;
        for (int i = 0; i < 4; i++) exp_lat[i] = PSP_LATCH_RST;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 4; i++) `CHK(lat[i], exp_lat[i])
        t_codes();
        t_no_load();
        t_power();
        t_mux();
        stop_test();
    end
endmodule // psp_serial_port_bench
`default_nettype wire
